// ==== rtl/mmf_mgmt_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// R01: with select bit 0 set, an external read of the driver status clears it.
// R02: microcore backdoor reads never cause any clear-on-read clearing.
// R03: bits 1-4 enable clearing of the diagnosis pairs from 0x162 to 0x169.
// R04: bits 5-8 enable clearing of the four microcore status registers.
// R05: the select register has nine r/w bits reset to zero, never locked.
// R06: a microcore write colliding with an external read is kept, not cleared.
// R07: writing 0x1337 to the key register clears the lock register.
// R08: a read-only word gives part code, layout and instruction revisions.
// R09: the controller checks the instruction revision before loading code.
// R10: the merged flag bus is the AND of both channel flag buses.
// R11: a pin in its default function leaves its flag bit on the merged bus.
// R12: a pin used as flag loses its original function.
// R13: a flag input replaces its bit after a three-cycle deglitch filter.
// R14: a flag output drives the merged bit straight onto the pin.
// R15: source 0 is default, source 1 dir 0 output, source 1 dir 1 input.
// R16: a set polarity bit inverts the flag between pin and flag bus.
// R17: each flag input pin passes two flip-flops before the filter.
module mmf_mgmt_regs #(
   parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
   parameter logic [3:0] LAYOUT_REV = 4'h1,
   parameter logic [3:0] ISA_REV = 4'h1
) (
   input wire logic core_clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic ce, // clock enable
   input wire logic ext_wr, // external spi register write strobe
   input wire logic ext_rd, // external spi register read strobe
   input wire logic [10:0] ext_addr, // external access address
   input wire logic [15:0] ext_wdata, // external write data
   input wire logic mc_wr, // microcore register write strobe
   input wire logic [10:0] mc_addr, // microcore write address
   input wire logic [15:0] chan1_flags, // channel one flag outputs
   input wire logic [15:0] chan2_flags, // channel two flag outputs
   input wire logic [12:0] flag_src, // source bits per pin
   input wire logic [12:0] flag_dir, // direction bits per pin
   input wire logic [12:0] flag_pol, // polarity bits per pin
   input wire logic [12:0] pin_in, // pin levels
   output logic [15:0] rdata_q, // read data
   output logic rvalid_q, // read data valid pulse
   output logic [8:0] cor_clear_q, // clear pulses, select bit order
   output logic lock_clear_q, // clears lock register
   output logic [15:0] flag_bus_q, // shared flag bus
   output logic [12:0] pin_out_q, // flag output level
   output logic [12:0] pin_oe_q, // pin driven as flag output
   output logic [12:0] pin_flag_mode_q // original function disconnected
);
   // ----------------------------------------
   // register access
   // ----------------------------------------
   logic [8:0] sel_q, sel_d;
   logic [15:0] rdata_d;
   logic rvalid_d;
   logic [8:0] cor_clear_d;
   logic lock_clear_d;
   logic [8:0] hit;
   logic collide;
   logic [10:0] diag_off;
   logic [10:0] stat_off;

   always_comb begin
      diag_off = ext_addr - mmf_pkg::ADDR_DIAG_BASE;
      stat_off = ext_addr - mmf_pkg::ADDR_STAT_BASE;
      hit = 9'h000;
      hit[mmf_pkg::COR_DRV_BIT] = (ext_addr == mmf_pkg::ADDR_DRV_STATUS);
      if (ext_addr >= mmf_pkg::ADDR_DIAG_BASE &&
          ext_addr <= mmf_pkg::ADDR_DIAG_LAST) begin
         hit[mmf_pkg::COR_DIAG_LSB + int'(diag_off[2:1])] = 1'b1; // R03
      end
      if (ext_addr >= mmf_pkg::ADDR_STAT_BASE &&
          ext_addr <= mmf_pkg::ADDR_STAT_LAST) begin
         hit[mmf_pkg::COR_STAT_LSB + int'(stat_off[1:0])] = 1'b1; // R04
      end
      // a refreshed value must survive until the next external read
      collide = mc_wr && (mc_addr == ext_addr); // R06
      cor_clear_d = 9'h000;
      if (ext_rd && !collide) begin
         cor_clear_d = sel_q & hit; // R01 R02 R03 R04
      end
      sel_d = sel_q;
      if (ext_wr && ext_addr == mmf_pkg::ADDR_COR_SEL) begin
         sel_d = ext_wdata[8:0]; // R05
      end
      lock_clear_d = ext_wr && ext_addr == mmf_pkg::ADDR_LOCK_KEY &&
                     ext_wdata == mmf_pkg::LOCK_KEY; // R07
      rvalid_d = ext_rd;
      rdata_d = 16'h0000;
      if (ext_rd && ext_addr == mmf_pkg::ADDR_COR_SEL) begin
         rdata_d = {7'h00, sel_q}; // R05
      end else if (ext_rd && ext_addr == mmf_pkg::ADDR_IDENT) begin
         rdata_d = {PART_CODE, LAYOUT_REV, ISA_REV}; // R08
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_q <= mmf_pkg::COR_SEL_RESET;
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
         cor_clear_q <= 9'h000;
         lock_clear_q <= 1'b0;
      end else if (ce) begin
         sel_q <= sel_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         cor_clear_q <= cor_clear_d;
         lock_clear_q <= lock_clear_d;
      end
   end

   // ----------------------------------------
   // flag bus combiner
   // ----------------------------------------
   logic [15:0] int_flags;
   logic [12:0] filt;
   logic [15:0] flag_bus_d;
   logic [12:0] pin_out_d, pin_oe_d, pin_mode_d;

   assign int_flags = chan1_flags & chan2_flags; // R10

   genvar g;
   generate
      for (g = 0; g < mmf_pkg::PIN_N; g++) begin : g_pin
         mmf_deglitch u_filt (
            .core_clk(core_clk),
            .rst(rst),
            .ce(ce),
            .pin_raw(pin_in[g]),
            .level_q(filt[g])
         );
      end
   endgenerate

   always_comb begin
      flag_bus_d = int_flags; // R11
      pin_mode_d = flag_src; // R12 R15
      pin_oe_d = flag_src & ~flag_dir; // R15
      pin_out_d = 13'h0000;
      for (int i = 0; i < mmf_pkg::PIN_N; i++) begin
         if (flag_src[i] && flag_dir[i]) begin
            flag_bus_d[i] = filt[i] ^ flag_pol[i]; // R13 R16
         end else if (flag_src[i]) begin
            pin_out_d[i] = int_flags[i] ^ flag_pol[i]; // R14 R16
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         flag_bus_q <= 16'h0000;
         pin_out_q <= 13'h0000;
         pin_oe_q <= 13'h0000;
         pin_flag_mode_q <= 13'h0000;
      end else if (ce) begin
         flag_bus_q <= flag_bus_d;
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
         pin_flag_mode_q <= pin_mode_d;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_drv_clear: assert property ( // R01
      ce && ext_rd && !mc_wr && sel_q[0] &&
      ext_addr == mmf_pkg::ADDR_DRV_STATUS |=> cor_clear_q[0])
      else $error("driver status not cleared on read");
   a_no_sel_clear: assert property ( // R01
      ce && !sel_q[0] |=> !cor_clear_q[0])
      else $error("clear without select bit");
   a_rd_only_clear: assert property ( // R02
      ce && !ext_rd |=> cor_clear_q == 9'h000)
      else $error("clear without an external read");
   a_diag_pair: assert property ( // R03
      ce && ext_rd && !mc_wr && sel_q[4] &&
      ext_addr == mmf_pkg::ADDR_DIAG_LAST |=> cor_clear_q == 9'h010)
      else $error("diag pair clear wrong");
   a_stat_core: assert property ( // R04
      ce && ext_rd && !mc_wr && sel_q[8] &&
      ext_addr == mmf_pkg::ADDR_STAT_LAST |=> cor_clear_q[8])
      else $error("status clear wrong");
   a_sel_write: assert property ( // R05
      ce && ext_wr && ext_addr == mmf_pkg::ADDR_COR_SEL |=>
      sel_q == $past(ext_wdata[8:0]))
      else $error("select register not written");
   a_collide_keep: assert property ( // R06
      ce && ext_rd && mc_wr && mc_addr == ext_addr |=> cor_clear_q == 9'h000)
      else $error("collision cleared fresh data");
   a_key_release: assert property ( // R07
      ce && ext_wr && ext_addr == mmf_pkg::ADDR_LOCK_KEY |=>
      lock_clear_q == ($past(ext_wdata) == mmf_pkg::LOCK_KEY))
      else $error("lock release wrong");
   a_ident_read: assert property ( // R08
      ce && ext_rd && ext_addr == mmf_pkg::ADDR_IDENT |=>
      rdata_q == {PART_CODE, LAYOUT_REV, ISA_REV} && rvalid_q)
      else $error("ident word wrong");
   a_flag_and: assert property ( // R10
      ce |=> flag_bus_q[15:13] ==
      $past(chan1_flags[15:13] & chan2_flags[15:13]))
      else $error("upper flags not merged");
   a_default_pin: assert property ( // R11
      ce && !flag_src[0] |=>
      flag_bus_q[0] == $past(int_flags[0]) && !pin_oe_q[0])
      else $error("default pin flag wrong");
   a_flag_mode: assert property ( // R12
      ce |=> pin_flag_mode_q == $past(flag_src))
      else $error("flag mode does not follow the source bits");
   a_flag_out: assert property ( // R14
      ce && flag_src[3] && !flag_dir[3] |=>
      pin_oe_q[3] && pin_out_q[3] == $past(int_flags[3] ^ flag_pol[3]))
      else $error("flag output wrong");
   a_flag_in: assert property ( // R13
      ce && flag_src[5] && flag_dir[5] |=>
      flag_bus_q[5] == $past(filt[5] ^ flag_pol[5]) && pin_flag_mode_q[5])
      else $error("flag input wrong");

   c_drv_clear: cover property (cor_clear_q[0]);
   c_collide: cover property (ext_rd && mc_wr && mc_addr == ext_addr);
   c_unlock: cover property (lock_clear_q);
   c_flag_in: cover property (flag_src[1] && flag_dir[1] && $changed(filt[1]));
endmodule

// ==== rtl/mmf_pkg.sv ====
package mmf_pkg;
   // ----------------------------------------
   // register map (word addresses)
   // ----------------------------------------
   localparam logic [10:0] ADDR_LOCK_KEY = 11'h1CF;
   localparam logic [10:0] ADDR_IDENT = 11'h1D5;
   localparam logic [10:0] ADDR_COR_SEL = 11'h4CE;
   localparam logic [10:0] ADDR_DIAG_BASE = 11'h162;
   localparam logic [10:0] ADDR_DIAG_LAST = 11'h169;
   localparam logic [10:0] ADDR_STAT_BASE = 11'h1E0;
   localparam logic [10:0] ADDR_STAT_LAST = 11'h1E3;
   localparam logic [10:0] ADDR_DRV_STATUS = 11'h1E4;
   // ----------------------------------------
   // fields and values
   // ----------------------------------------
   localparam logic [15:0] LOCK_KEY = 16'h1337;
   localparam int COR_BITS = 9;
   localparam int COR_DRV_BIT = 0;
   localparam int COR_DIAG_LSB = 1;
   localparam int COR_STAT_LSB = 5;
   localparam logic [8:0] COR_SEL_RESET = 9'h000;
   localparam int ID_PART_LSB = 8;
   localparam int ID_LAYOUT_LSB = 4;
   localparam int ID_ISA_LSB = 0;
   localparam int FLAG_W = 16;
   localparam int PIN_N = 13;
   // ----------------------------------------
   // deglitch timing
   // ----------------------------------------
   localparam int FILT_CYC = 3;
   localparam int FILT_NS = 125;
   localparam int CLK_MHZ = 50;
   localparam logic [1:0] FILT_CNT_MAX = 2'(FILT_CYC - 1);
endpackage

// ==== rtl/mmf_deglitch.sv ====
`timescale 1ns/1ps
module mmf_deglitch (
   input wire logic core_clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic ce, // clock enable
   input wire logic pin_raw, // asynchronous pin level
   output logic level_q // filtered level
);
   logic sync1_q, sync1_d;
   logic sync2_q, sync2_d;
   logic [1:0] cnt_q, cnt_d;
   logic level_d;

   always_comb begin
      sync1_d = pin_raw; // R17
      sync2_d = sync1_q; // R17
      cnt_d = cnt_q;
      level_d = level_q;
      if (sync2_q == level_q) begin
         cnt_d = 2'h0;
      end else if (cnt_q == mmf_pkg::FILT_CNT_MAX) begin
         level_d = sync2_q; // R13
         cnt_d = 2'h0;
      end else begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         cnt_q <= 2'h0;
         level_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   a_filt_stable: assert property (@(posedge core_clk) disable iff (rst) // R13
      (ce && $changed(level_q)) |-> $past(sync2_q) == level_q)
      else $error("filtered level changed without a held input");
endmodule

// ==== tb/mmf_spi_master.sv ====
`timescale 1ns/1ps
module mmf_spi_master (
   input wire logic core_clk, // system clock
   output logic ext_wr, // write strobe
   output logic ext_rd, // read strobe
   output logic [10:0] ext_addr, // access address
   output logic [15:0] ext_wdata, // write data
   input wire logic [15:0] rdata_q, // read data
   input wire logic rvalid_q // read valid
);
   initial begin
      ext_wr = 1'b0;
      ext_rd = 1'b0;
      ext_addr = 11'h000;
      ext_wdata = 16'h0000;
   end
   // released address and data lines show inverted values so a stale match cannot pass
   task automatic acc(input logic w, input logic [10:0] a,
         input logic [15:0] dd);
      @(posedge core_clk);
      ext_wr <= w;
      ext_rd <= ~w;
      ext_addr <= a;
      ext_wdata <= dd;
      @(posedge core_clk);
      ext_wr <= 1'b0;
      ext_rd <= 1'b0;
      ext_addr <= ~a;
      ext_wdata <= ~dd;
      #1;
   endtask
   task automatic wr(input logic [10:0] a, input logic [15:0] dd);
      acc(1'b1, a, dd);
   endtask
   task automatic rd(input logic [10:0] a, output logic [15:0] dd,
         output logic vv);
      acc(1'b0, a, 16'h0000);
      dd = rdata_q;
      vv = rvalid_q;
   endtask
   // microcode is loaded only when the instruction revision matches
   function automatic logic isa_ok(input logic [15:0] id,
         input logic [3:0] want);
      return id[3:0] === want;
   endfunction
endmodule

// ==== tb/mmf_mgmt_regs_tb.sv ====
`timescale 1ns/1ps
module mmf_mgmt_regs_tb;
   localparam logic [7:0] PART = 8'hC3; // arbitrary value
   localparam logic [3:0] LAY = 4'h2;
   localparam logic [3:0] ISA = 4'h4;
   logic core_clk, rst, ext_wr, ext_rd, mc_wr, rvalid_q, lock_clear_q, v;
   logic [10:0] ext_addr, mc_addr, a;
   logic [15:0] ext_wdata, chan1_flags, chan2_flags, rdata_q, flag_bus_q, d;
   logic [12:0] flag_src, flag_dir, flag_pol, pin_in;
   logic [12:0] pin_out_q, pin_oe_q, pin_flag_mode_q;
   logic [8:0] cor_clear_q;
   int error_cnt, n_tests, k, b;
   logic ce;
   mmf_mgmt_regs #(.PART_CODE(PART), .LAYOUT_REV(LAY), .ISA_REV(ISA)) dut_u (
      .core_clk(core_clk), .rst(rst), .ce(ce), .ext_wr(ext_wr),
      .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .mc_wr(mc_wr), .mc_addr(mc_addr), .chan1_flags(chan1_flags),
      .chan2_flags(chan2_flags), .flag_src(flag_src), .flag_dir(flag_dir),
      .flag_pol(flag_pol), .pin_in(pin_in), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .cor_clear_q(cor_clear_q),
      .lock_clear_q(lock_clear_q), .flag_bus_q(flag_bus_q),
      .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
      .pin_flag_mode_q(pin_flag_mode_q));
   mmf_spi_master mst_u (
      .core_clk(core_clk), .ext_wr(ext_wr), .ext_rd(ext_rd),
      .ext_addr(ext_addr), .ext_wdata(ext_wdata), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string m);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic rdc(input logic [10:0] ad, input logic [8:0] c);
      mst_u.rd(ad, d, v);
      chk({15'h0, v}, 16'h0001, "rvalid");
      chk({7'h0, cor_clear_q}, {7'h0, c}, "clear pulse");
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      error_cnt = 0;
      n_tests = 0;
      rst = 1'b1;
      ce = 1'b1;
      mc_wr = 1'b0;
      mc_addr = 11'h000;
      chan1_flags = 16'h0000;
      chan2_flags = 16'h0000;
      flag_src = 13'h0000;
      flag_dir = 13'h0000;
      flag_pol = 13'h0000;
      pin_in = 13'h0000;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rdc(11'h4CE, 9'h000);
      chk(d, 16'h0000, "select reset");
      rdc(11'h1D5, 9'h000);
      chk(d, {PART, LAY, ISA}, "ident");
      chk({15'h0, mst_u.isa_ok(d, ISA)}, 16'h0001, "isa");
      rdc(11'h7FF, 9'h000);
      chk(d, 16'h0000, "unmapped");
      mst_u.wr(11'h4CE, 16'hFFFF);
      rdc(11'h4CE, 9'h000);
      chk(d, 16'h01FF, "select rw");
      $display("test registers done");
      for (k = 0; k < 13; k++) begin
         if (k == 0) begin
            a = mmf_pkg::ADDR_DRV_STATUS;
            b = 0;
         end else if (k < 9) begin
            a = 11'h162 + 11'(k - 1);
            b = 1 + (k - 1) / 2;
         end else begin
            a = mmf_pkg::ADDR_STAT_BASE + 11'(k - 9);
            b = k - 4;
         end
         rdc(a, 9'h001 << b);
      end
      mst_u.wr(11'h4CE, 16'h01FE);
      rdc(mmf_pkg::ADDR_DRV_STATUS, 9'h000);
      @(posedge core_clk);
      mc_wr <= 1'b1;
      mc_addr <= 11'h163;
      rdc(11'h163, 9'h000);
      @(posedge core_clk);
      mc_wr <= 1'b0;
      rdc(11'h163, 9'h002);
      $display("test clear on read done");
      mst_u.wr(11'h1CF, 16'h1336);
      chk({15'h0, lock_clear_q}, 16'h0000, "bad key");
      mst_u.wr(11'h1CF, 16'h1337);
      chk({15'h0, lock_clear_q}, 16'h0001, "good key");
      $display("test unlock done");
      @(posedge core_clk);
      chan1_flags <= 16'hF0F0;
      chan2_flags <= 16'hFF00;
      step(2);
      chk(flag_bus_q, 16'hF000, "merged");
      chk({3'h0, pin_flag_mode_q}, 16'h0000, "default pins");
      @(posedge core_clk);
      flag_src <= 13'h1FFF;
      flag_pol <= 13'h0F0F;
      step(2);
      chk(flag_bus_q, 16'hF000, "out bus");
      chk({3'h0, pin_out_q}, 16'h1F0F, "out pin");
      chk({3'h0, pin_oe_q}, 16'h1FFF, "out oe");
      chk({3'h0, pin_flag_mode_q}, 16'h1FFF, "flag mode");
      @(posedge core_clk);
      flag_dir <= 13'h1FFF;
      flag_pol <= 13'h0001;
      step(3);
      chk(flag_bus_q, 16'hE001, "in bus");
      chk({3'h0, pin_oe_q}, 16'h0000, "in oe");
      @(posedge core_clk);
      pin_in <= 13'h0020;
      repeat (2) @(posedge core_clk);
      pin_in <= 13'h0000;
      step(8);
      chk(flag_bus_q, 16'hE001, "glitch dropped");
      @(posedge core_clk);
      pin_in <= 13'h0020;
      k = 0;
      while (flag_bus_q[5] !== 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      chk(flag_bus_q, 16'hE021, "in level");
      // two sync stages, the filter, then the bus register
      chk({15'h0, k == 3 + mmf_pkg::FILT_CYC}, 16'h0001,
          "filter delay");
      if (k >= 20) begin
         error_cnt++;
         $display("wrong value at %0t: flag input timed out", $time);
      end else begin
         $display("test flags done");
         @(posedge core_clk);
         ce <= 1'b0;
         pin_in <= 13'h0000;
         chan1_flags <= 16'h0000;
         step(8);
         chk(flag_bus_q, 16'hE021, "frozen bus");
         @(posedge core_clk);
         ce <= 1'b1;
         step(7);
         chk(flag_bus_q, 16'h0001, "thawed bus");
         @(posedge core_clk);
         rst <= 1'b1;
         step(2);
         chk({3'h0, pin_flag_mode_q}, 16'h0000, "mode in reset");
         @(posedge core_clk);
         rst <= 1'b0;
         rdc(mmf_pkg::ADDR_COR_SEL, 9'h000);
         chk(d, 16'h0000, "select after reset");
         $display("test freeze and reset done");
      end
      results();
   end
endmodule
